// ### rtl/sleep_and_module_stop_control.sv
// sleep sequencing, module clock stop and mode pin latch
// assumes cpu and interrupt logic on clk; pins arrive asynchronously
`timescale 1ns/1ps
module sleep_and_module_stop_control (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic sleep_exec,
  input wire logic interrupt_block_bit,
  input wire logic module_irq,
  input wire logic nmi_pin,
  input wire logic [4:0] irq_pins,
  input wire logic [3:0] irl_pins_n,
  input wire logic [5:0] mode_pins,
  input wire logic manual_rst_n,
  output logic cpu_halt,
  output logic clock_out_en,
  output logic standby_active,
  output logic int_start,
  output logic [11:0] int_event_code,
  output logic [11:0] int_event_code_b,
  output logic status_pin_hi,
  output logic status_pin_lo,
  output logic [5:0] mode_latched,
  output power_down_pkg::module_clk_en_t module_clk_en,
  output logic adc_reg_init
);
  logic [power_down_pkg::SYNC_W-1:0] sync1_q;
  logic [power_down_pkg::SYNC_W-1:0] sync2_q;
  logic [power_down_pkg::SYNC_W-1:0] pins_w;
  logic [7:0] ctrl1_q;
  logic [7:0] ctrl2_q;
  logic ack_q;
  logic [31:0] readdata_q;
  power_down_pkg::power_state_t state_q;
  power_down_pkg::power_state_t state_d;
  logic [1:0] status_q;
  logic [1:0] status_d;
  logic int_start_q;
  logic [11:0] code_q;
  logic [11:0] code_b_q;
  logic [5:0] mode_q;
  logic [1:0] boot_q;
  logic nmi_s;
  logic [4:0] irq_s;
  logic [3:0] irl_s;
  logic [5:0] mode_s;
  logic mrst;
  logic req;
  logic wr_take;
  logic rd_take;
  logic sel1;
  logic sel2;
  logic wr_lane;
  logic [7:0] rd_byte;
  logic sleeping;
  logic wake;
  logic accept;
  logic [11:0] code_d;
  logic relatch;
  logic [power_down_pkg::STOP_HI:power_down_pkg::STOP_LO] en_w;

  assign pins_w = {nmi_pin, irq_pins, irl_pins_n, mode_pins, manual_rst_n};

  // two-stage synchroniser for all pin inputs
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_q <= power_down_pkg::SYNC_IDLE;
      sync2_q <= power_down_pkg::SYNC_IDLE;
    end
    else
    begin
      sync1_q <= pins_w;
      sync2_q <= sync1_q;
    end
  end

  assign nmi_s = sync2_q[16];
  assign irq_s = sync2_q[15:11];
  assign irl_s = sync2_q[10:7];
  assign mode_s = sync2_q[6:1];
  assign mrst = ~sync2_q[0];

  // bus decode, one wait cycle per access
  assign req = read | write;
  assign waitrequest = req & ~ack_q;
  assign wr_take = write & ack_q;
  assign rd_take = read & ~ack_q;
  assign sel1 = address == power_down_pkg::ADDR_STANDBY_CONTROL_1;
  assign sel2 = address == power_down_pkg::ADDR_STANDBY_CONTROL_2;
  assign wr_lane = wr_take & byteenable[0];
  assign rd_byte = sel1 ? (ctrl1_q & power_down_pkg::CTRL1_WMASK) :
                   sel2 ? (ctrl2_q & power_down_pkg::CTRL2_WMASK) : 8'h00;
  assign readdata = readdata_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ack_q <= 1'b0;
      readdata_q <= power_down_pkg::RDATA_RESET;
    end
    else
    begin
      ack_q <= req & ~ack_q;
      if (rd_take)
        readdata_q <= {24'h00_0000, rd_byte};
    end
  end

  // standby control registers, manual reset clears them too
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl1_q <= power_down_pkg::CTRL1_RESET;
      ctrl2_q <= power_down_pkg::CTRL2_RESET;
    end
    else if (mrst)
    begin
      ctrl1_q <= power_down_pkg::CTRL1_RESET;
      ctrl2_q <= power_down_pkg::CTRL2_RESET;
    end
    else if (wr_lane)
    begin
      if (sel1)
        ctrl1_q <= writedata[7:0] & power_down_pkg::CTRL1_WMASK;
      if (sel2)
        ctrl2_q <= writedata[7:0] & power_down_pkg::CTRL2_WMASK;
    end
  end

  // module clock enables, one per stop bit
  genvar gi;
  generate
    for (gi = power_down_pkg::STOP_LO; gi <= power_down_pkg::STOP_HI; gi = gi + 1)
    begin : g_stop
      assign en_w[gi] = ~ctrl2_q[gi];
    end
  endgenerate
  assign module_clk_en = power_down_pkg::module_clk_en_t'(en_w);
  assign adc_reg_init = ctrl2_q[power_down_pkg::ADC_BIT];

  // wake sources, priority nmi, irq, irl, module
  assign sleeping = state_q != power_down_pkg::ST_RUN;
  assign wake = nmi_s | (|irq_s) | (irl_s != power_down_pkg::IRL_NONE) | module_irq;
  assign accept = sleeping & wake;
  assign code_d = nmi_s ? power_down_pkg::CODE_NMI :
                  (|irq_s) ? power_down_pkg::CODE_IRQ :
                  (irl_s != power_down_pkg::IRL_NONE) ? power_down_pkg::CODE_IRL :
                  power_down_pkg::CODE_MODULE;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      power_down_pkg::ST_RUN:
      begin
        if (sleep_exec && !ctrl1_q[power_down_pkg::SSEL_BIT])
          state_d = power_down_pkg::ST_SLEEP;
        else if (sleep_exec)
          state_d = power_down_pkg::ST_STANDBY;
      end
      power_down_pkg::ST_SLEEP:
      begin
        if (accept)
          state_d = power_down_pkg::ST_RUN;
      end
      power_down_pkg::ST_STANDBY:
      begin
        if (accept)
          state_d = power_down_pkg::ST_RUN;
      end
      default:
      begin
        state_d = power_down_pkg::ST_RUN;
      end
    endcase
  end

  assign status_d = (state_d == power_down_pkg::ST_SLEEP) ? power_down_pkg::STATUS_SLEEP :
                    (state_d == power_down_pkg::ST_STANDBY) ? power_down_pkg::STATUS_STANDBY :
                    power_down_pkg::STATUS_RUN;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= power_down_pkg::ST_RUN;
      status_q <= power_down_pkg::STATUS_RESET;
      int_start_q <= 1'b0;
      code_q <= power_down_pkg::CODE_RESET;
      code_b_q <= power_down_pkg::CODE_RESET;
    end
    else if (mrst)
    begin
      state_q <= power_down_pkg::ST_RUN;
      status_q <= power_down_pkg::STATUS_RESET;
      int_start_q <= 1'b0;
      code_q <= power_down_pkg::CODE_RESET;
      code_b_q <= power_down_pkg::CODE_RESET;
    end
    else
    begin
      state_q <= state_d;
      status_q <= status_d;
      int_start_q <= accept;
      if (accept)
      begin
        code_q <= code_d;
        code_b_q <= code_d;
      end
    end
  end

  // mode pins: caught after power-on, again on standby exit or manual reset if enabled
  assign relatch = ctrl2_q[power_down_pkg::RELATCH_BIT] &
                   ((state_q == power_down_pkg::ST_STANDBY) & accept | mrst);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      boot_q <= 2'b00;
      mode_q <= power_down_pkg::MODE_RESET;
    end
    else
    begin
      // power-on latch waits until the synchroniser holds real pin values
      if (boot_q != 2'b11)
        boot_q <= 2'(boot_q + 2'b01);
      if (boot_q == power_down_pkg::BOOT_LATCH || relatch)
        mode_q <= mode_s;
    end
  end

  assign cpu_halt = sleeping;
  assign clock_out_en = state_q != power_down_pkg::ST_STANDBY;
  assign standby_active = state_q == power_down_pkg::ST_STANDBY;
  assign int_start = int_start_q;
  assign int_event_code = code_q;
  assign int_event_code_b = code_b_q;
  assign status_pin_hi = status_q[1];
  assign status_pin_lo = status_q[0];
  assign mode_latched = mode_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_sleep_cmd;
    state_q == power_down_pkg::ST_RUN && sleep_exec && !ctrl1_q[7] && !mrst;
  endsequence
  sequence s_in_sleep;
    status_pin_hi && !status_pin_lo && cpu_halt && clock_out_en;
  endsequence

  a_resv_read_zero: assert property (read && !waitrequest && sel2 |-> readdata[31:7] == 25'h0 && !readdata[0]) else $error("reserved bits read nonzero");
  a_ctrl2_write: assert property (write && !waitrequest && sel2 && byteenable[0] && !mrst |=> ctrl2_q == ($past(writedata[7:0]) & 8'h7E)) else $error("control 2 write lost");
  a_break_stop: assert property (wr_lane && sel2 && writedata[5] && !mrst |=> !module_clk_en.break_unit) else $error("break clock not stopped");
  a_dma_stop: assert property (wr_lane && sel2 && !writedata[4] && !mrst |=> module_clk_en.dma) else $error("dma clock not running");
  a_dac_stop: assert property (wr_lane && sel2 && writedata[3] && !mrst |=> !module_clk_en.dac) else $error("dac clock not stopped");
  a_adc_stop: assert property (wr_lane && sel2 && writedata[2] && !mrst |=> !module_clk_en.adc && adc_reg_init) else $error("adc not stopped and initialised");
  a_fifo_stop: assert property (wr_lane && sel2 && writedata[1] && !mrst |=> !module_clk_en.fifo_serial) else $error("fifo serial clock not stopped");
  a_sleep_entry: assert property (s_sleep_cmd |=> s_in_sleep) else $error("sleep not entered");
  a_sleep_hold: assert property (s_sleep_cmd ##1 (!wake && !mrst) [*2] |-> s_in_sleep) else $error("sleep not held");
  a_wake_block: assert property (state_q == power_down_pkg::ST_SLEEP && wake && interrupt_block_bit && !mrst |=> int_start && !status_pin_hi && !status_pin_lo) else $error("wake refused");
  a_resume_status: assert property (sleeping && accept && !mrst |=>
    !status_pin_hi && !status_pin_lo && !cpu_halt) else $error("status not back to run");
  a_code_both: assert property (int_start |-> int_event_code == int_event_code_b && $past(accept)) else $error("event codes differ");
  a_mrst_exit: assert property (mrst |=> state_q == power_down_pkg::ST_RUN && !cpu_halt) else $error("manual reset kept sleep");
  a_standby_entry: assert property (state_q == power_down_pkg::ST_RUN && sleep_exec && ctrl1_q[7] && !mrst |=> standby_active && !status_pin_hi && status_pin_lo) else $error("standby not entered");
  a_relatch_mode: assert property (standby_active && accept && ctrl2_q[6] |=> mode_latched == $past(mode_s)) else $error("mode pins not relatched");
endmodule : sleep_and_module_stop_control

// ### common/power_down_pkg.sv
// constants and types for the sleep and module stop controller
// assumes a byte-addressed Avalon-MM register slave with 32-bit data
package power_down_pkg;
  localparam logic [3:0] ADDR_STANDBY_CONTROL_1 = 4'h0;
  localparam logic [3:0] ADDR_STANDBY_CONTROL_2 = 4'h4;
  localparam int SSEL_BIT = 7;
  localparam int RELATCH_BIT = 6;
  localparam int BREAK_BIT = 5;
  localparam int DMA_BIT = 4;
  localparam int DAC_BIT = 3;
  localparam int ADC_BIT = 2;
  localparam int FIFO_BIT = 1;
  localparam int STOP_LO = 1;
  localparam int STOP_HI = 5;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] CTRL2_RESET = 8'h00;
  localparam logic [7:0] CTRL1_WMASK = 8'h80;
  localparam logic [7:0] CTRL2_WMASK = 8'h7E;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  localparam logic [5:0] MODE_RESET = 6'h00;
  localparam logic [3:0] IRL_NONE = 4'hF;
  localparam int SYNC_W = 17;
  // idle pin levels: nmi low, irq low, irl none, mode zero, manual reset released
  localparam logic [16:0] SYNC_IDLE = 17'h0_0781;
  localparam logic [1:0] BOOT_LATCH = 2'b10;
  // interrupt source codes, values arbitrary
  localparam logic [11:0] CODE_NMI = 12'h001;
  localparam logic [11:0] CODE_IRQ = 12'h002;
  localparam logic [11:0] CODE_IRL = 12'h003;
  localparam logic [11:0] CODE_MODULE = 12'h004;
  localparam logic [11:0] CODE_RESET = 12'h000;
  localparam logic [1:0] STATUS_RESET = 2'b11;
  localparam logic [1:0] STATUS_SLEEP = 2'b10;
  localparam logic [1:0] STATUS_STANDBY = 2'b01;
  localparam logic [1:0] STATUS_RUN = 2'b00;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SLEEP = 2'b01,
    ST_STANDBY = 2'b10
  } power_state_t;
  typedef struct packed {
    logic break_unit;
    logic dma;
    logic dac;
    logic adc;
    logic fifo_serial;
  } module_clk_en_t;
endpackage : power_down_pkg

// ### testbench/wake_source_model.sv
// partner: interrupt sources that wake the controller
// assumes the bench picks one source and drops it after the wake is taken
`timescale 1ns/1ps
module wake_source_model (
  input wire logic [2:0] wake_kind,
  output logic nmi_pin,
  output logic [4:0] irq_pins,
  output logic [3:0] irl_pins_n,
  output logic module_irq
);
  // released pins return to their idle level
  assign nmi_pin = (wake_kind == 3'h1);
  assign irq_pins = (wake_kind == 3'h2) ? 5'h04 : 5'h00;
  assign irl_pins_n = (wake_kind == 3'h3) ? 4'h9 : 4'hF;
  assign module_irq = (wake_kind == 3'h4);
endmodule : wake_source_model

// ### testbench/test_sleep_and_module_stop_control.sv
// bench: register bus, sleep entry and wake, standby select, mode relatch
// assumes the wake source model in its own file
`timescale 1ns/1ps
module test_sleep_and_module_stop_control;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic sleep_exec = 1'b0;
  logic blk = 1'b1;
  logic manual_rst_n = 1'b1;
  logic [5:0] mode_pins = 6'h15;
  logic [5:0] mp;
  logic [2:0] wake_kind = 3'h0;
  logic [31:0] readdata;
  logic waitrequest, nmi, mirq, halt, clk_out, software_standby_select, int_start, hi, lo, adc_init;
  logic [4:0] irq;
  logic [3:0] encoded_level_interrupt;
  logic [11:0] code_a, code_b;
  logic [5:0] mode_latched;
  power_down_pkg::module_clk_en_t clk_en;
  logic [31:0] exp_rd[$];
  logic [11:0] exp_code[$];
  logic [11:0] codes[4];
  logic [7:0] v;
  logic [11:0] last_code = power_down_pkg::CODE_RESET;
  int err_total = 0;
  int check_count = 0;
  int seed = 32'h67f6_d839;
  always #20 clk = ~clk;
  wake_source_model u_src (.wake_kind(wake_kind), .nmi_pin(nmi), .irq_pins(irq),
    .irl_pins_n(encoded_level_interrupt), .module_irq(mirq));
  sleep_and_module_stop_control u_dut (.clk(clk), .nrst(nrst), .address(address),
    .read(read), .write(write), .byteenable(4'h1), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .sleep_exec(sleep_exec),
    .interrupt_block_bit(blk), .module_irq(mirq), .nmi_pin(nmi), .irq_pins(irq),
    .irl_pins_n(encoded_level_interrupt), .mode_pins(mode_pins), .manual_rst_n(manual_rst_n),
    .cpu_halt(halt), .clock_out_en(clk_out), .standby_active(software_standby_select),
    .int_start(int_start), .int_event_code(code_a), .int_event_code_b(code_b),
    .status_pin_hi(hi), .status_pin_lo(lo), .mode_latched(mode_latched),
    .module_clk_en(clk_en), .adc_reg_init(adc_init));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic bus(input logic we, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    read <= ~we;
    write <= we;
    address <= a;
    writedata <= {24'h00_0000, d};
    do
    begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    exp_rd.push_back(exp);
    bus(1'b0, a, 8'h00);
  endtask : rd
  task automatic sleep_in;
    @(posedge clk);
    sleep_exec <= 1'b1;
    @(posedge clk);
    sleep_exec <= 1'b0;
    #1;
    check("halt", 32'(halt), 32'h1);
    check("sleep_code", 32'(code_a), 32'(last_code));
  endtask : sleep_in
  task automatic wake(input logic [2:0] k, input logic [11:0] code);
    int n;
    n = 0;
    exp_code.push_back(code);
    @(posedge clk);
    wake_kind <= k;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (int_start !== 1'b1 && n < 20);
    last_code = code;
    check("wake_seen", 32'(int_start), 32'h1);
    check("wake_status", 32'({hi, lo}), 32'h0);
    check("wake_halt", 32'(halt), 32'h0);
    @(posedge clk);
    wake_kind <= 3'h0;
    repeat (6) @(posedge clk);
  endtask : wake
  always @(posedge clk)
  begin
    if (read && waitrequest === 1'b0 && exp_rd.size() > 0)
      check("readdata", readdata, exp_rd.pop_front());
    if (int_start === 1'b1 && exp_code.size() > 0)
    begin
      check("code_a", 32'(code_a), 32'(exp_code[0]));
      check("code_b", 32'(code_b), 32'(exp_code.pop_front()));
    end
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    stop_test;
  end
  initial
  begin
    codes = '{power_down_pkg::CODE_NMI, power_down_pkg::CODE_IRQ,
      power_down_pkg::CODE_IRL, power_down_pkg::CODE_MODULE};
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rd(4'h4, 32'h0000_0000);
    check("clk_en_reset", 32'(clk_en), 32'h1F);
    bus(1'b1, 4'h8, 8'hFF);
    rd(4'h8, 32'h0000_0000);
    for (int i = 0; i < 5; i++)
    begin
      v = (i == 0) ? 8'hFF : 8'($random(seed));
      bus(1'b1, 4'h4, v);
      rd(4'h4, {24'h00_0000, v & 8'h7E});
      check("clk_en", 32'(clk_en), 32'(5'(~v[5:1])));
      check("adc_init", 32'(adc_init), 32'(v[2]));
    end
    bus(1'b1, 4'h0, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      sleep_in;
      check("sleep_status", 32'({hi, lo}), 32'h2);
      check("sleep_clk_out", 32'({clk_out, software_standby_select}), 32'h2);
      check("sleep_clk_en", 32'(clk_en), 32'(5'(~v[5:1])));
      wake(3'(k + 1), codes[k]);
    end
    mp = 6'($random(seed));
    mode_pins <= mp;
    bus(1'b1, 4'h4, 8'h40);
    bus(1'b1, 4'h0, 8'h80);
    sleep_in;
    check("software_standby_select_status", 32'({hi, lo, software_standby_select}), 32'h3);
    wake(3'h1, power_down_pkg::CODE_NMI);
    check("relatch_on", 32'(mode_latched), 32'(mp));
    bus(1'b1, 4'h4, 8'h00);
    mode_pins <= ~mp;
    sleep_in;
    wake(3'h2, power_down_pkg::CODE_IRQ);
    check("relatch_off", 32'(mode_latched), 32'(mp));
    bus(1'b1, 4'h0, 8'h00);
    bus(1'b1, 4'h4, 8'h3E);
    sleep_in;
    @(posedge clk);
    manual_rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    check("mrst_status", 32'({hi, lo}), 32'h3);
    @(posedge clk);
    manual_rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    check("mrst_exit", 32'({halt, hi, lo}), 32'h0);
    rd(4'h4, 32'h0000_0000);
    repeat (2) @(posedge clk);
    stop_test;
  end
endmodule : test_sleep_and_module_stop_control
